/* cpr_charge_param_regs.v */
// Charge parameter registers with field decode and host-link watchdog
// How it works
// - Pre-charge current code in bits 7..4, 128mA steps
// - Termination current code in bits 3..0, 128mA steps
// - Current register resets to 0x11
// - Voltage code bits 7..2, 16mV over 3.504V
// - Voltage register resets to 0xB2, 4.208V
// - Bit 1 picks 2.8V or 3.0V threshold
// - Bit 0 picks 100mV or 300mV recharge drop
// - Bit 7 enables termination, default on
// - Bit 6 selects early status below 800mA
// - Bits 5..4 set watchdog off/40/80/160 s
// - Bit 3 enables safety timer, default on
// - Bits 2..1 pick 5/8/12/20 hour timer
// - Timer register resets to 0x9A
// - All bits read back last written value
// - Watchdog restart bit self-clears after restart
`timescale 1ns/1ps
`include "cpr_regs.vh"

module cpr_charge_param_regs #(
    parameter SEC_CYCLES = `CPR_CLK_HZ
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Register port from the serial engine
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // Watchdog restart control bit
    input wire wdog_restart_wr_in,
    output reg wdog_restart_bit_out,
    output reg wdog_expire_out,
    // Raw fields to the charging loops
    output wire [3:0] precharge_current_code_out,
    output wire [3:0] termination_current_code_out,
    output wire [5:0] charge_voltage_code_out,
    output wire fastcharge_entry_threshold_out,
    output wire recharge_offset_select_out,
    output wire term_enable_out,
    output wire term_status_early_out,
    output wire [1:0] wdog_period_select_out,
    output wire safety_timer_enable_out,
    output wire [1:0] fastcharge_duration_select_out,
    // Decoded set points
    output reg [11:0] precharge_ma_out,
    output reg [11:0] termination_ma_out,
    output reg [12:0] charge_voltage_mv_out,
    output reg [11:0] fastcharge_entry_mv_out,
    output reg [8:0] recharge_drop_mv_out,
    output reg [11:0] status_threshold_ma_out,
    output reg [4:0] fastcharge_hours_out
);

    // ==========================================================
    // Port timing in brief
    // A write strobe is taken at a rising edge. The whole byte lands
    // at that edge and the raw field outputs follow straight away.
    // The decoded set points are registered and trail by one cycle,
    // which keeps the adders and the saturation off the field paths.
    // A read strobe is answered one cycle later. Read valid pulses for
    // one cycle and the read data holds until the next read.
    // A read and a write to the same offset in one cycle return the
    // value from before the write, since the read samples storage.
    // Unmapped offsets: writes are dropped and reads answer zero.
    // The reserved low bit of the timer register is kept as written;
    // the host is expected to write zero there, so nothing masks it.
    // Voltage codes above the top step are kept as written, but the
    // decoded set point stops at the top step.
    // The watchdog counts one-second ticks from a divider. A restart,
    // a change of period or a disabled period all clear the count, so
    // a new period counts from zero; the divider is not cleared, so its first second may be short.
    // The restart bit is high for one cycle after a write of 1 and
    // then clears itself; a new write of 1 in that cycle keeps it set.
    // While reset is held the decoded outputs read zero. They take
    // their default values at the first edge after release.
    // The strobe port is the only way in; the serial engine that
    // drives it sits outside this block.
    // Every output is registered or comes straight from a register,
    // so nothing here adds a combinational path from the strobes.

    // ==========================================================
    // Register storage
    reg [7:0] prechg_term_q;
    reg [7:0] chg_volt_q;
    reg [7:0] term_timer_q;
    wire hit_cur;
    wire hit_volt;
    wire hit_tmr;

    // Offset decode, shared by reads and writes
    assign hit_cur = (reg_addr_in == `CPR_OFS_PRECHG_TERM);
    assign hit_volt = (reg_addr_in == `CPR_OFS_CHG_VOLT);
    assign hit_tmr = (reg_addr_in == `CPR_OFS_TERM_TIMER);

    // Writes land whole; unmapped offsets are ignored
    // No commit step: storage feeds the field outputs directly
    always @(posedge clk_in) begin
        if (rst_in) begin
            prechg_term_q <= `CPR_RST_PRECHG_TERM;
            chg_volt_q <= `CPR_RST_CHG_VOLT;
            term_timer_q <= `CPR_RST_TERM_TIMER;
        end else if (reg_wr_in) begin
            if (hit_cur) begin
                prechg_term_q <= reg_wdata_in;
            end
            if (hit_volt) begin
                chg_volt_q <= reg_wdata_in;
            end
            if (hit_tmr) begin
                // Reserved bit 0 is stored as written
                term_timer_q <= reg_wdata_in;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    // Reads sample storage before a same-cycle write lands
    always @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                if (hit_cur) begin
                    reg_rdata_out <= prechg_term_q;
                end else if (hit_volt) begin
                    reg_rdata_out <= chg_volt_q;
                end else if (hit_tmr) begin
                    reg_rdata_out <= term_timer_q;
                end else begin
                    reg_rdata_out <= 8'h00;
                end
            end
        end
    end

    // ==========================================================
    // Raw fields, straight from storage so writes apply at once
    assign precharge_current_code_out =
        prechg_term_q[`CPR_PRECHG_MSB:`CPR_PRECHG_LSB];
    assign termination_current_code_out =
        prechg_term_q[`CPR_TERM_MSB:`CPR_TERM_LSB];
    assign charge_voltage_code_out =
        chg_volt_q[`CPR_CHARGE_VOLTAGE_CODE_MSB:`CPR_CHARGE_VOLTAGE_CODE_LSB];
    assign fastcharge_entry_threshold_out =
        chg_volt_q[`CPR_LOWV_BIT];
    assign recharge_offset_select_out = chg_volt_q[`CPR_RECHG_BIT];
    assign term_enable_out = term_timer_q[`CPR_EN_TERM_BIT];
    assign term_status_early_out = term_timer_q[`CPR_TERM_STAT_BIT];
    assign wdog_period_select_out =
        term_timer_q[`CPR_WDOG_MSB:`CPR_WDOG_LSB];
    assign safety_timer_enable_out = term_timer_q[`CPR_EN_TIMER_BIT];
    assign fastcharge_duration_select_out =
        term_timer_q[`CPR_CHG_TMR_MSB:`CPR_CHG_TMR_LSB];

    // ==========================================================
    // Decoded set points, registered one cycle behind the fields
    reg [5:0] vcode_sat;
    wire [11:0] prechg_ma_d;
    wire [11:0] term_ma_d;
    wire [12:0] volt_mv_d;
    always @* begin
        // Codes above the top valid step saturate at 4.400 V
        if (charge_voltage_code_out > `CPR_CHARGE_VOLTAGE_CODE_MAX_CODE) begin
            vcode_sat = `CPR_CHARGE_VOLTAGE_CODE_MAX_CODE;
        end else begin
            vcode_sat = charge_voltage_code_out;
        end
    end

    // Current limits: the offset plus one step per code count
    assign prechg_ma_d = `CPR_CUR_OFS_MA +
        `CPR_CUR_STEP_MA * {8'h00, precharge_current_code_out};
    assign term_ma_d = `CPR_CUR_OFS_MA +
        `CPR_CUR_STEP_MA * {8'h00, termination_current_code_out};

    // Voltage: the offset plus one step per saturated code count
    assign volt_mv_d = `CPR_CHARGE_VOLTAGE_CODE_OFS_MV +
        `CPR_CHARGE_VOLTAGE_CODE_STEP_MV * {7'h00, vcode_sat};

    always @(posedge clk_in) begin
        if (rst_in) begin
            precharge_ma_out <= 12'h000;
            termination_ma_out <= 12'h000;
            charge_voltage_mv_out <= 13'h0000;
            fastcharge_entry_mv_out <= 12'h000;
            recharge_drop_mv_out <= 9'h000;
            status_threshold_ma_out <= 12'h000;
            fastcharge_hours_out <= 5'h00;
        end else begin
            precharge_ma_out <= prechg_ma_d;
            termination_ma_out <= term_ma_d;
            charge_voltage_mv_out <= volt_mv_d;
            fastcharge_entry_mv_out <= fastcharge_entry_threshold_out ?
                `CPR_LOWV_HI_MV : `CPR_LOWV_LO_MV;
            recharge_drop_mv_out <= recharge_offset_select_out ?
                `CPR_RECHG_HI_MV : `CPR_RECHG_LO_MV;
            // Status pin follows termination current or the early level
            if (term_status_early_out) begin
                status_threshold_ma_out <= `CPR_EARLY_STAT_MA;
            end else begin
                status_threshold_ma_out <= term_ma_d;
            end
            case (fastcharge_duration_select_out)
                2'b00: fastcharge_hours_out <= `CPR_TMR_5_HRS;
                2'b01: fastcharge_hours_out <= `CPR_TMR_8_HRS;
                2'b10: fastcharge_hours_out <= `CPR_TMR_12_HRS;
                default: fastcharge_hours_out <= `CPR_TMR_20_HRS;
            endcase
        end
    end

    // ==========================================================
    // Host-link watchdog
    reg [24:0] tick_cnt_q;
    reg sec_tick_q;
    reg [7:0] sec_cnt_q;
    reg [7:0] wdog_limit;
    reg [1:0] wdog_sel_q;
    wire wdog_sel_chg;
    wire wdog_clear;
    wire wdog_last;
    wire [7:0] tmr_rst_w;

    // One-second enable pulse from the clock
    // SEC_CYCLES sets the tick rate, so a bench can run it fast
    always @(posedge clk_in) begin
        if (rst_in) begin
            tick_cnt_q <= 25'h0000000;
            sec_tick_q <= 1'b0;
        end else if (tick_cnt_q == SEC_CYCLES[24:0] - 25'h0000001) begin
            tick_cnt_q <= 25'h0000000;
            sec_tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 25'h0000001;
            sec_tick_q <= 1'b0;
        end
    end

    // Period in seconds for the selected code
    always @* begin
        case (wdog_period_select_out)
            2'b01: wdog_limit = `CPR_WDOG_40_S;
            2'b10: wdog_limit = `CPR_WDOG_80_S;
            2'b11: wdog_limit = `CPR_WDOG_160_S;
            default: wdog_limit = 8'h00;
        endcase
    end

    // A new period takes effect from a fresh count
    assign wdog_sel_chg = (wdog_sel_q != wdog_period_select_out);

    // Reasons to start the count afresh
    assign wdog_clear = (wdog_limit == 8'h00) || wdog_restart_bit_out ||
        wdog_sel_chg;

    // Last second of the selected period
    assign wdog_last = (sec_cnt_q == wdog_limit - 8'h01);

    // Period code as the timer register holds it after reset
    assign tmr_rst_w = `CPR_RST_TERM_TIMER;

    // Seconds counter; expiry is a one-cycle pulse
    // The count runs only while a period is selected
    always @(posedge clk_in) begin
        if (rst_in) begin
            sec_cnt_q <= 8'h00;
            wdog_expire_out <= 1'b0;
            wdog_sel_q <= tmr_rst_w[`CPR_WDOG_MSB:`CPR_WDOG_LSB];
        end else begin
            wdog_sel_q <= wdog_period_select_out;
            wdog_expire_out <= 1'b0;
            if (wdog_clear) begin
                sec_cnt_q <= 8'h00;
            end else if (sec_tick_q) begin
                if (wdog_last) begin
                    sec_cnt_q <= 8'h00;
                    wdog_expire_out <= 1'b1;
                end else begin
                    sec_cnt_q <= sec_cnt_q + 8'h01;
                end
            end
        end
    end

    // Restart bit: set by a write of 1, cleared once the count restarts
    // A write of 1 in the cycle of the self-clear keeps the bit set
    always @(posedge clk_in) begin
        if (rst_in) begin
            wdog_restart_bit_out <= 1'b0;
        end else if (wdog_restart_wr_in) begin
            wdog_restart_bit_out <= 1'b1;
        end else if (wdog_restart_bit_out) begin
            wdog_restart_bit_out <= 1'b0;
        end
    end

endmodule // cpr_charge_param_regs

/* cpr_regs.vh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef CPR_REGS_VH
`define CPR_REGS_VH

// ==========================================================
// Register offsets
`define CPR_OFS_PRECHG_TERM 8'h03
`define CPR_OFS_CHG_VOLT 8'h04
`define CPR_OFS_TERM_TIMER 8'h05

// ==========================================================
// Reset values
`define CPR_RST_PRECHG_TERM 8'h11
`define CPR_RST_CHG_VOLT 8'hB2
`define CPR_RST_TERM_TIMER 8'h9A

// ==========================================================
// Field positions
`define CPR_PRECHG_MSB 7
`define CPR_PRECHG_LSB 4
`define CPR_TERM_MSB 3
`define CPR_TERM_LSB 0
`define CPR_CHARGE_VOLTAGE_CODE_MSB 7
`define CPR_CHARGE_VOLTAGE_CODE_LSB 2
`define CPR_LOWV_BIT 1
`define CPR_RECHG_BIT 0
`define CPR_EN_TERM_BIT 7
`define CPR_TERM_STAT_BIT 6
`define CPR_WDOG_MSB 5
`define CPR_WDOG_LSB 4
`define CPR_EN_TIMER_BIT 3
`define CPR_CHG_TMR_MSB 2
`define CPR_CHG_TMR_LSB 1

// ==========================================================
// Analog scaling, in mA, mV and hours
`define CPR_CUR_OFS_MA 12'h080
`define CPR_CUR_STEP_MA 12'h080
`define CPR_CHARGE_VOLTAGE_CODE_OFS_MV 13'h0DB0
`define CPR_CHARGE_VOLTAGE_CODE_STEP_MV 13'h0010
`define CPR_CHARGE_VOLTAGE_CODE_MAX_CODE 6'h38
`define CPR_LOWV_LO_MV 12'hAF0
`define CPR_LOWV_HI_MV 12'hBB8
`define CPR_RECHG_LO_MV 9'h064
`define CPR_RECHG_HI_MV 9'h12C
`define CPR_EARLY_STAT_MA 12'h320
`define CPR_TMR_5_HRS 5'h05
`define CPR_TMR_8_HRS 5'h08
`define CPR_TMR_12_HRS 5'h0C
`define CPR_TMR_20_HRS 5'h14

// ==========================================================
// Watchdog timing
`define CPR_CLK_HZ 25000000
`define CPR_WDOG_40_S 8'h28
`define CPR_WDOG_80_S 8'h50
`define CPR_WDOG_160_S 8'hA0

`endif

/* cpr_regs_asserts.sv */
// Checker that watches the register port and fields of the block
`timescale 1ns/1ps
module cpr_regs_asserts (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Register port
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    input wire reg_rvalid_out,
    // Watchdog restart
    input wire wdog_restart_wr_in,
    input wire wdog_restart_bit_out,
    // Fields and decoded voltage
    input wire [3:0] precharge_current_code_out,
    input wire [3:0] termination_current_code_out,
    input wire [5:0] charge_voltage_code_out,
    input wire fastcharge_entry_threshold_out,
    input wire recharge_offset_select_out,
    input wire [12:0] charge_voltage_mv_out
);
    // ==========================================================
    // Helper state
    reg [5:0] vcode_q;
    wire [7:0] cur_w = {precharge_current_code_out,
        termination_current_code_out};
    wire [7:0] volt_w = {charge_voltage_code_out,
        fastcharge_entry_threshold_out, recharge_offset_select_out};

    // Voltage code one cycle back, matches the decode latency
    always @(posedge clk_in) vcode_q <= charge_voltage_code_out;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ==========================================================
    // Assertions
    reset_vals_a: assert property (
        $past(rst_in) |-> cur_w == 8'h11 && volt_w == 8'hB2)
        else $error("fields differ from reset values");
    volt_decode_a: assert property (
        !$past(rst_in) |-> charge_voltage_mv_out == 13'h0DB0 +
        13'h0010 * ((vcode_q > 6'h38) ? 6'h38 : vcode_q))
        else $error("voltage set point wrong");
    restart_bit_a: assert property (
        wdog_restart_wr_in |=> wdog_restart_bit_out ##1 !wdog_restart_bit_out)
        else $error("restart bit did not self clear");
    read_valid_a: assert property (
        !$past(rst_in) |-> reg_rvalid_out == $past(reg_rd_in))
        else $error("read valid not one cycle after strobe");
    unmapped_zero_a: assert property (
        reg_rd_in && (reg_addr_in < 8'h03 || reg_addr_in > 8'h05)
        |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    cur_write_a: assert property (
        reg_wr_in && reg_addr_in == 8'h03 |=> cur_w == $past(reg_wdata_in))
        else $error("current fields did not follow write");
    volt_write_a: assert property (
        reg_wr_in && reg_addr_in == 8'h04 |=> volt_w == $past(reg_wdata_in))
        else $error("voltage fields did not follow write");
    cur_readback_a: assert property (
        reg_rvalid_out && $past(reg_addr_in) == 8'h03 && !$past(reg_wr_in)
        |-> reg_rdata_out == cur_w)
        else $error("current register readback wrong");

    // Main scenarios reached
    cover property (reg_wr_in && reg_addr_in == 8'h05);
    cover property (reg_rd_in && reg_addr_in == 8'h06);
    cover property (wdog_restart_wr_in);
endmodule // cpr_regs_asserts

bind cpr_charge_param_regs cpr_regs_asserts chk (.clk_in, .rst_in,
    .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .reg_rvalid_out, .wdog_restart_wr_in, .wdog_restart_bit_out,
    .precharge_current_code_out, .termination_current_code_out,
    .charge_voltage_code_out, .fastcharge_entry_threshold_out,
    .recharge_offset_select_out, .charge_voltage_mv_out);

/* cpr_host_model.sv */
// Host model that drives the register port of the block
`timescale 1ns/1ps
module cpr_host_model (
    // Clock
    input wire clk_in,
    // Register port toward the block
    output reg reg_wr_out = 1'b0,
    output reg reg_rd_out = 1'b0,
    output reg [7:0] reg_addr_out = 8'h00,
    output reg [7:0] reg_wdata_out = 8'h00,
    output reg wdog_restart_wr_out = 1'b0,
    input wire [7:0] reg_rdata_in,
    input wire reg_rvalid_in
);
    // Write one byte; reserved timer bit always goes out as zero
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clk_in);
            reg_wr_out <= 1'b1;
            reg_addr_out <= a;
            reg_wdata_out <= (a == 8'h05) ? {v[7:1], 1'b0} : v;
            @(posedge clk_in);
            reg_wr_out <= 1'b0;
            reg_addr_out <= ~a;
            reg_wdata_out <= ~v;
            #1;
        end
    endtask

    // Read one byte, answer comes one cycle after the strobe
    task rd(input [7:0] a, output [7:0] v);
        begin
            @(posedge clk_in);
            reg_rd_out <= 1'b1;
            reg_addr_out <= a;
            @(posedge clk_in);
            reg_rd_out <= 1'b0;
            reg_addr_out <= ~a;
            #1;
            v = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
        end
    endtask

    // Pulse the watchdog restart bit
    task restart;
        begin
            @(posedge clk_in);
            wdog_restart_wr_out <= 1'b1;
            @(posedge clk_in);
            wdog_restart_wr_out <= 1'b0;
            #1;
        end
    endtask
endmodule // cpr_host_model

/* cpr_charge_param_regs_bench.sv */
// Self-checking bench for the charge parameter register block
`timescale 1ns/1ps
module cpr_charge_param_regs_bench;
    // ==========================================================
    // Clock, reset and wiring
    reg clk_in = 1'b0;
    reg rst_in = 1'b1;
    wire wr, rd, rs, rv, rbit, expire, te, ts, se;
    wire [7:0] addr, wdata, rdata;
    wire [3:0] pc;
    wire [1:0] dsel, ws;
    wire [11:0] pma, tma, ema, sma;
    wire [12:0] vmv;
    wire [8:0] rmv;
    wire [4:0] hrs;
    integer mismatches = 0;
    integer checked = 0;
    integer i, n;
    reg [7:0] d, v;
    reg [4:0] eh;

    // Free-running 25 MHz clock
    always #20 clk_in = ~clk_in;

    cpr_charge_param_regs #(.SEC_CYCLES(10)) dut (.clk_in(clk_in),
        .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rv), .wdog_restart_wr_in(rs),
        .wdog_restart_bit_out(rbit), .wdog_expire_out(expire),
        .precharge_current_code_out(pc), .termination_current_code_out(),
        .charge_voltage_code_out(), .fastcharge_entry_threshold_out(),
        .recharge_offset_select_out(), .term_enable_out(te),
        .term_status_early_out(ts), .wdog_period_select_out(ws),
        .safety_timer_enable_out(se), .fastcharge_duration_select_out(dsel),
        .precharge_ma_out(pma), .termination_ma_out(tma),
        .charge_voltage_mv_out(vmv), .fastcharge_entry_mv_out(ema),
        .recharge_drop_mv_out(rmv), .status_threshold_ma_out(sma),
        .fastcharge_hours_out(hrs));

    cpr_host_model host (.clk_in(clk_in), .reg_wr_out(wr), .reg_rd_out(rd),
        .reg_addr_out(addr), .reg_wdata_out(wdata),
        .wdog_restart_wr_out(rs), .reg_rdata_in(rdata), .reg_rvalid_in(rv));

    // ==========================================================
    // Shared tasks
    task chk(input [12:0] got, input [12:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task rchk(input [7:0] a, input [7:0] e);
        begin
            host.rd(a, d);
            chk(d, e);
        end
    endtask

    task cnt_exp(input integer lim);
        begin
            n = 0;
            while (expire !== 1'b1 && n < lim) begin
                @(posedge clk_in);
                #1;
                n = n + 1;
            end
            if (n >= lim) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t wait %h limit %h", $time, n, lim);
                tally_and_finish;
            end
        end
    endtask

    task quiet(input integer lim);
        begin
            n = 0;
            repeat (lim) begin
                @(posedge clk_in);
                #1;
                if (expire === 1'b1)
                    n = n + 1;
            end
        end
    endtask

    task tally_and_finish;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ==========================================================
    // Scenarios
    task t_defaults;
        begin
            chk(vmv, 13'h1070);
            chk(pma, 12'h100);
            chk(ema, 12'hBB8);
            chk(rmv, 9'h064);
            chk(hrs, 5'h08);
            chk(tma, 12'h100);
            chk(sma, 12'h100);
            chk(te, 1'b1);
            chk(ts, 1'b0);
            chk(ws, 2'h1);
            chk(se, 1'b1);
            rchk(8'h03, 8'h11);
            rchk(8'h04, 8'hB2);
            rchk(8'h05, 8'h9A);
        end
    endtask

    task t_rw;
        begin
            host.wr(8'h03, 8'hF0);
            chk(pc, 4'hF);
            host.wr(8'h04, 8'h55);
            @(posedge clk_in);
            #1;
            chk(vmv, 13'h0F00);
            chk(ema, 12'hAF0);
            chk(rmv, 9'h12C);
            host.wr(8'h04, 8'hFF);
            @(posedge clk_in);
            #1;
            chk(pma, 12'h800);
            chk(tma, 12'h080);
            chk(vmv, 13'h1130);
            chk(ema, 12'hBB8);
            rchk(8'h03, 8'hF0);
            rchk(8'h04, 8'hFF);
        end
    endtask

    task t_timer;
        for (i = 0; i < 4; i = i + 1) begin
            v = {~i[0], i[0], 2'h0, i[1], i[1:0], 1'b1};
            host.wr(8'h05, v);
            chk(dsel, i[1:0]);
            chk(te, v[7]);
            chk(ts, v[6]);
            chk(ws, v[5:4]);
            chk(se, v[3]);
            @(posedge clk_in);
            #1;
            eh = i[1] ? (i[0] ? 5'h14 : 5'h0C) : (i[0] ? 5'h08 : 5'h05);
            chk(hrs, eh);
            chk(sma, i[0] ? 12'h320 : 12'h080);
            rchk(8'h05, {v[7:1], 1'b0});
        end
    endtask

    task t_wdog;
        begin
            host.wr(8'h06, 8'hFF);
            rchk(8'h06, 8'h00);
            rchk(8'h03, 8'hF0);
            quiet(500);
            chk(n[12:0], 13'h0000);
            host.wr(8'h05, 8'h9A);
            repeat (200) @(posedge clk_in);
            host.restart;
            chk(rbit, 1'b1);
            @(posedge clk_in);
            #1;
            chk(rbit, 1'b0);
            cnt_exp(1000);
            chk(n >= 390 && n <= 401, 1'b1);
            host.wr(8'h05, 8'hAA);
            cnt_exp(1000);
            chk(n >= 790 && n <= 802, 1'b1);
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        t_defaults;
        t_rw;
        t_timer;
        t_wdog;
        tally_and_finish;
    end
endmodule // cpr_charge_param_regs_bench
